/* File: tifs_core_model.sv */
// Model of the processor core that issues instruction boundaries and takes the stack bytes.
`timescale 1ns/1ps
module tifs_core_model (
  input  wire logic        ref_clk,       // System clock.
  input  wire logic        rst,           // Synchronous reset.
  input  wire logic        slow,          // Two-cycle instructions.
  input  wire logic        core_hold,     // Core halted.
  input  wire logic        pc_load,       // Vector load.
  input  wire logic [15:0] pc_value,      // Vector.
  input  wire logic        stack_push,    // Push pulse.
  input  wire logic [7:0]  stack_byte,    // Byte pushed.
  output logic             insn_boundary, // Instruction completes.
  output logic [15:0]      core_pc,       // Program counter.
  output logic [15:0]      pushed,        // Last two bytes pushed, high byte last.
  output logic [15:0]      push_pc        // Program counter while pushing.
);
  logic phase_q;
  // ==========================================================================
  // Sequencing
  // A slow instruction only completes every other cycle, so entry must wait for it.
  assign insn_boundary = !core_hold && (!slow || phase_q);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_q <= 1'b0;
      core_pc <= 16'h0100;
    end else begin
      phase_q <= !phase_q;
      if (pc_load) begin
        core_pc <= pc_value;
      end else if (insn_boundary) begin
        core_pc <= core_pc + 16'h0001;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (stack_push) begin
      pushed  <= {stack_byte, pushed[15:8]};
    end
  end
  // The address the sequencer must push is the one presented at the last completed instruction.
  always_ff @(posedge ref_clk) begin
    if (insn_boundary) begin
      push_pc <= core_pc;
    end
  end
endmodule : tifs_core_model

/* File: tifs_ctrl.sv */
// Timer interrupt flags, dispatch sequencer and sleep control with an AXI4-Lite slave.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module tifs_ctrl
  import tifs_pkg::*;
(
  input  wire logic        ref_clk,        // System clock, 20 MHz.
  input  wire logic        rst,            // Synchronous reset, active high.
  // AXI4-Lite slave.
  input  wire logic [31:0] s_axi_awaddr,   // Write address.
  input  wire logic        s_axi_awvalid,  // Write address valid.
  output logic             s_axi_awready,  // Write address ready.
  input  wire logic [31:0] s_axi_wdata,    // Write data.
  input  wire logic [3:0]  s_axi_wstrb,    // Write byte strobes.
  input  wire logic        s_axi_wvalid,   // Write data valid.
  output logic             s_axi_wready,   // Write data ready.
  output logic [1:0]       s_axi_bresp,    // Write response.
  output logic             s_axi_bvalid,   // Write response valid.
  input  wire logic        s_axi_bready,   // Write response ready.
  input  wire logic [31:0] s_axi_araddr,   // Read address.
  input  wire logic        s_axi_arvalid,  // Read address valid.
  output logic             s_axi_arready,  // Read address ready.
  output logic [31:0]      s_axi_rdata,    // Read data.
  output logic [1:0]       s_axi_rresp,    // Read response.
  output logic             s_axi_rvalid,   // Read data valid.
  input  wire logic        s_axi_rready,   // Read data ready.
  // Timer event sources, one-cycle pulses; mode inputs are levels.
  input  wire logic        t0_overflow,    // Timer0 overflow.
  input  wire logic        t0_leave_zero,  // Timer0 count advanced from zero.
  input  wire logic        t0_pwm_mode,    // Timer0 in pulse-width mode.
  input  wire logic        t0_compare_hit, // Timer0 count equals compare value.
  input  wire logic        t0_async,       // Timer0 clocked asynchronously.
  input  wire logic        t1_overflow,    // Timer1 overflow.
  input  wire logic        t1_leave_zero,  // Timer1 count advanced from zero.
  input  wire logic        t1_pwm_mode,    // Timer1 in pulse-width mode.
  input  wire logic        t1_compare_a_hit, // Timer1 compare A match.
  input  wire logic        t1_compare_b_hit, // Timer1 compare B match.
  input  wire logic        t1_capture_done,  // Count copied to capture value.
  input  wire logic        t2_overflow,    // Timer2 overflow.
  input  wire logic        t2_leave_zero,  // Timer2 count advanced from zero.
  input  wire logic        t2_pwm_mode,    // Timer2 in pulse-width mode.
  input  wire logic        t2_compare_hit, // Timer2 count equals compare value.
  // Core sequencing.
  input  wire logic        insn_boundary,  // Current instruction completes this cycle.
  input  wire logic        sleep_insn,     // Sleep instruction completes this cycle.
  input  wire logic        reti_insn,      // Return-from-interrupt starts this cycle.
  input  wire logic [15:0] core_pc,        // Program counter to push.
  input  wire logic        ext_wake,       // External level, watchdog or reset wake.
  output logic             core_hold,      // Core halted by the sequencer or sleep.
  output logic             pc_load,        // Pulse: load program counter.
  output logic [15:0]      pc_value,       // Value to load.
  output logic             stack_push,     // Pulse: push a byte.
  output logic             stack_pop,      // Pulse: pop a byte.
  output logic [7:0]       stack_byte,     // Byte pushed.
  output logic [15:0]      stack_ptr,      // Stack pointer.
  output logic             osc_stop,       // External oscillator stopped.
  output logic             sleeping        // Sleep state.
);

  // ==========================================================================
  // Register bus
  // ==========================================================================
  logic [7:0]  flags_q;
  logic [7:0]  enables_q;
  logic [3:0]  core_ctl_q;
  logic        wr_fire;
  logic [9:0]  wr_addr;
  logic [7:0]  w1c_mask;
  logic [7:0]  vec_clear;
  logic [7:0]  hw_set;
  logic [7:0]  pending;
  tifs_state_t state_q;
  logic [2:0]  cnt_q;
  logic [2:0]  sel_q;
  logic [15:0] ret_pc_q;
  logic        gie;

  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  assign wr_addr = s_axi_awaddr[9:0];
  assign gie     = core_ctl_q[TIFS_GIE_BIT];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= TIFS_RESP_OKAY;
    end else begin
      s_axi_awready <= wr_fire;
      s_axi_wready  <= wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (s_axi_awaddr[31:10] == 22'h0 &&
                         (wr_addr == TIFS_FLAGS_ADDR || wr_addr == TIFS_ENABLES_ADDR ||
                          wr_addr == TIFS_CORE_CTL_ADDR || wr_addr == TIFS_STATUS_ADDR))
                        ? TIFS_RESP_OKAY : TIFS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= TIFS_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= TIFS_RESP_OKAY;
        if (s_axi_araddr[31:10] != 22'h0) begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= TIFS_RESP_SLVERR;
        end else begin
          case (s_axi_araddr[9:0])
            TIFS_FLAGS_ADDR:    s_axi_rdata <= {24'h000000, flags_q};
            TIFS_ENABLES_ADDR:  s_axi_rdata <= {24'h000000, enables_q};
            TIFS_CORE_CTL_ADDR: s_axi_rdata <= {28'h0000000, core_ctl_q};
            TIFS_STATUS_ADDR:   s_axi_rdata <= {21'h000000, sel_q, sleeping, 4'h0,
                                                state_q};
            default: begin
              s_axi_rdata <= 32'h0000_0000;
              s_axi_rresp <= TIFS_RESP_SLVERR;
            end
          endcase
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      enables_q  <= TIFS_ENABLES_RST;
      core_ctl_q <= TIFS_CORE_CTL_RST;
    end else if (wr_fire && s_axi_wstrb[0] && s_axi_awaddr[31:10] == 22'h0) begin
      if (wr_addr == TIFS_ENABLES_ADDR) enables_q <= s_axi_wdata[7:0];
      if (wr_addr == TIFS_CORE_CTL_ADDR) core_ctl_q <= s_axi_wdata[3:0];
    end
  end

  // ==========================================================================
  // Event flags
  // ==========================================================================
  always_comb begin
    hw_set = 8'h00;
    hw_set[TIFS_T2_CMP]  = t2_compare_hit;
    hw_set[TIFS_T2_OVF]  = t2_pwm_mode ? t2_leave_zero : t2_overflow;
    hw_set[TIFS_T1_CAP]  = t1_capture_done;
    hw_set[TIFS_T1_CMPA] = t1_compare_a_hit;
    hw_set[TIFS_T1_CMPB] = t1_compare_b_hit;
    hw_set[TIFS_T1_OVF]  = t1_pwm_mode ? t1_leave_zero : t1_overflow;
    hw_set[TIFS_T0_CMP]  = t0_compare_hit;
    hw_set[TIFS_T0_OVF]  = t0_pwm_mode ? t0_leave_zero : t0_overflow;
  end

  assign w1c_mask = (wr_fire && s_axi_wstrb[0] && s_axi_awaddr[31:10] == 22'h0 &&
                     wr_addr == TIFS_FLAGS_ADDR) ? s_axi_wdata[7:0] : 8'h00;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      assign vec_clear[gi] = (state_q == TIFS_ENTRY) && (cnt_q == 3'd0) &&
                             (sel_q == 3'(gi));
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          flags_q[gi] <= TIFS_FLAGS_RST[gi];
        end else if (hw_set[gi]) begin
          flags_q[gi] <= 1'b1;
        end else if (w1c_mask[gi] || vec_clear[gi]) begin
          flags_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign pending = flags_q & enables_q & {8{gie}};

  // ==========================================================================
  // Dispatch and sleep sequencer
  // ==========================================================================
  // Highest priority is bit 0 (highest vector).
  logic [2:0] pick;
  always_comb begin
    pick = 3'd0;
    for (int i = 7; i >= 0; i--) begin
      if (pending[i]) pick = 3'(i);
    end
  end

  logic wake_ok;
  always_comb begin
    case (core_ctl_q[TIFS_SM_HI:TIFS_SM_LO])
      TIFS_SM_IDLE: wake_ok = |pending;
      TIFS_SM_PSV:  wake_ok = ext_wake || (t0_async &&
                      (pending[TIFS_T0_OVF] || pending[TIFS_T0_CMP]));
      default:      wake_ok = ext_wake;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q    <= TIFS_RUN;
      cnt_q      <= 3'd0;
      sel_q      <= 3'd0;
      ret_pc_q   <= 16'h0000;
      core_hold  <= 1'b0;
      pc_load    <= 1'b0;
      pc_value   <= 16'h0000;
      stack_push <= 1'b0;
      stack_pop  <= 1'b0;
      stack_byte <= 8'h00;
      stack_ptr  <= 16'h0000;
      osc_stop   <= 1'b0;
      sleeping   <= 1'b0;
    end else begin
      pc_load    <= 1'b0;
      stack_push <= 1'b0;
      stack_pop  <= 1'b0;
      case (state_q)
        TIFS_RUN, TIFS_AFTER: begin
          if (reti_insn && state_q == TIFS_RUN) begin
            state_q   <= TIFS_RETURN;
            cnt_q     <= 3'd0;
            core_hold <= 1'b1;
          end else if (insn_boundary && |pending && state_q == TIFS_RUN) begin
            state_q   <= TIFS_ENTRY;
            cnt_q     <= 3'd0;
            sel_q     <= pick;
            ret_pc_q  <= core_pc;
            core_hold <= 1'b1;
          end else if (sleep_insn && core_ctl_q[TIFS_SLEEP_BIT]) begin
            state_q   <= TIFS_SLEEP;
            core_hold <= 1'b1;
            sleeping  <= 1'b1;
            osc_stop  <= core_ctl_q[TIFS_SM_HI];
          end else if (insn_boundary) begin
            state_q <= TIFS_RUN;
          end
        end
        TIFS_SLEEP: begin
          if (wake_ok) begin
            state_q   <= TIFS_RUN;
            core_hold <= 1'b0;
            sleeping  <= 1'b0;
            osc_stop  <= 1'b0;
          end
        end
        TIFS_ENTRY: begin
          cnt_q <= cnt_q + 3'd1;
          if (cnt_q < 3'd2) begin
            stack_push <= 1'b1;
            stack_byte <= (cnt_q == 3'd0) ? ret_pc_q[7:0] : ret_pc_q[15:8];
            stack_ptr  <= stack_ptr - 16'(TIFS_SP_STEP >> 1);
          end
          if (cnt_q == 3'(TIFS_ENTRY_CYC - 1)) begin
            pc_load  <= 1'b1;
            pc_value <= TIFS_VEC_T0_OVF - 16'(sel_q) * TIFS_VEC_STEP;
            state_q  <= TIFS_JUMP;
            cnt_q    <= 3'd0;
          end
        end
        TIFS_JUMP: begin
          cnt_q <= cnt_q + 3'd1;
          if (cnt_q == 3'(TIFS_JUMP_CYC - 1)) begin
            state_q   <= TIFS_HANDLER;
            core_hold <= 1'b0;
          end
        end
        TIFS_HANDLER: begin
          if (reti_insn) begin
            state_q   <= TIFS_RETURN;
            cnt_q     <= 3'd0;
            core_hold <= 1'b1;
          end
        end
        TIFS_RETURN: begin
          cnt_q <= cnt_q + 3'd1;
          if (cnt_q < 3'd2) begin
            stack_pop <= 1'b1;
            stack_ptr <= stack_ptr + 16'(TIFS_SP_STEP >> 1);
          end
          if (cnt_q == 3'(TIFS_RETURN_CYC - 1)) begin
            state_q   <= TIFS_AFTER;
            core_hold <= 1'b0;
          end
        end
        default: state_q <= TIFS_RUN;
      endcase
    end
  end

endmodule : tifs_ctrl

/* File: tifs_ctrl_asserts.sv */
// Checker for entry, return, stack and sleep relations at the timer irq block ports.
`timescale 1ns/1ps
module tifs_ctrl_chk (
  input wire logic        ref_clk,    // System clock.
  input wire logic        rst,        // Synchronous reset.
  input wire logic        sleep_insn, // Sleep instruction.
  input wire logic        core_hold,  // Core halted.
  input wire logic        pc_load,    // Vector load pulse.
  input wire logic [15:0] pc_value,   // Vector loaded.
  input wire logic        stack_push, // Push pulse.
  input wire logic        stack_pop,  // Pop pulse.
  input wire logic [15:0] stack_ptr,  // Stack pointer.
  input wire logic        osc_stop,   // Oscillator stopped.
  input wire logic        sleeping    // Sleep state.
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Properties
  property p_push_pair; $rose(stack_push) |=> stack_push ##1 !stack_push; endproperty
  a_push_pair: assert property (p_push_pair) else $error("push not two bytes");
  property p_sp_down; $rose(stack_push) |-> ##2 stack_ptr == $past(stack_ptr, 3) - 16'h0002; endproperty
  a_sp_down: assert property (p_sp_down) else $error("stack pointer not down by two");
  property p_entry_len; $rose(stack_push) |-> ##3 pc_load; endproperty
  a_entry_len: assert property (p_entry_len) else $error("vector load not in entry cycle");
  property p_jump; pc_load |-> core_hold [*3] ##1 !core_hold; endproperty
  a_jump: assert property (p_jump) else $error("jump not three cycles");
  property p_vector; pc_load |-> !pc_value[0] && pc_value >= 16'h0012 && pc_value <= 16'h0020; endproperty
  a_vector: assert property (p_vector) else $error("vector outside timer table");
  property p_pop_pair; $rose(stack_pop) |=> stack_pop ##1 !stack_pop; endproperty
  a_pop_pair: assert property (p_pop_pair) else $error("pop not two bytes");
  property p_sp_up; $rose(stack_pop) |-> ##2 stack_ptr == $past(stack_ptr, 3) + 16'h0002; endproperty
  a_sp_up: assert property (p_sp_up) else $error("stack pointer not up by two");
  property p_sleep_cause; $rose(sleeping) |-> $past(sleep_insn) || $past(sleep_insn, 2); endproperty
  a_sleep_cause: assert property (p_sleep_cause) else $error("sleep without instruction");
  property p_osc; osc_stop |-> sleeping; endproperty
  a_osc: assert property (p_osc) else $error("oscillator stopped while awake");
  property p_sleep_halt; sleeping |-> core_hold; endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("core runs while asleep");
  c_entry: cover property (pc_load && pc_value == 16'h0020);
  c_sleep: cover property ($rose(sleeping));
  c_return: cover property ($rose(stack_pop));
endmodule : tifs_ctrl_chk

bind tifs_ctrl tifs_ctrl_chk i_chk (.ref_clk, .rst, .sleep_insn, .core_hold, .pc_load,
  .pc_value, .stack_push, .stack_pop, .stack_ptr, .osc_stop, .sleeping);

/* File: tifs_pkg.sv */
// Package with register map, field positions, vectors and sequencing counts for the timer irq block.
package tifs_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] TIFS_FLAGS_IDX    = 8'h36;
  localparam logic [7:0] TIFS_ENABLES_IDX  = 8'h37;
  localparam logic [7:0] TIFS_CORE_CTL_IDX = 8'h40;
  localparam logic [7:0] TIFS_STATUS_IDX   = 8'h41;
  localparam logic [9:0] TIFS_FLAGS_ADDR    = {TIFS_FLAGS_IDX, 2'b00};
  localparam logic [9:0] TIFS_ENABLES_ADDR  = {TIFS_ENABLES_IDX, 2'b00};
  localparam logic [9:0] TIFS_CORE_CTL_ADDR = {TIFS_CORE_CTL_IDX, 2'b00};
  localparam logic [9:0] TIFS_STATUS_ADDR   = {TIFS_STATUS_IDX, 2'b00};

  localparam logic [7:0] TIFS_FLAGS_RST    = 8'h00;
  localparam logic [7:0] TIFS_ENABLES_RST  = 8'h00;
  localparam logic [3:0] TIFS_CORE_CTL_RST = 4'h0;

  // Flag bit positions, also enable bit positions.
  localparam int TIFS_T0_OVF = 0;
  localparam int TIFS_T0_CMP = 1;
  localparam int TIFS_T1_OVF = 2;
  localparam int TIFS_T1_CMPB = 3;
  localparam int TIFS_T1_CMPA = 4;
  localparam int TIFS_T1_CAP = 5;
  localparam int TIFS_T2_OVF = 6;
  localparam int TIFS_T2_CMP = 7;

  // Core control fields: global enable, sleep allow, sleep select.
  localparam int TIFS_GIE_BIT   = 0;
  localparam int TIFS_SLEEP_BIT = 1;
  localparam int TIFS_SM_LO     = 2;
  localparam int TIFS_SM_HI     = 3;

  localparam logic [1:0] TIFS_SM_IDLE = 2'b00;
  localparam logic [1:0] TIFS_SM_PDN  = 2'b10;
  localparam logic [1:0] TIFS_SM_PSV  = 2'b11;

  // Vector of the lowest-numbered flag index source; lower vectors for higher bits.
  localparam logic [15:0] TIFS_VEC_T0_OVF = 16'h0020;
  localparam logic [15:0] TIFS_VEC_STEP   = 16'h0002;

  // ==========================================================================
  // Sequencing counts
  // ==========================================================================
  localparam int         TIFS_ENTRY_CYC  = 4;
  localparam int         TIFS_JUMP_CYC   = 3;
  localparam int         TIFS_RETURN_CYC = 4;
  localparam logic [1:0] TIFS_SP_STEP    = 2'd2;

  localparam logic [1:0] TIFS_RESP_OKAY   = 2'b00;
  localparam logic [1:0] TIFS_RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    TIFS_RUN, TIFS_ENTRY, TIFS_JUMP, TIFS_HANDLER, TIFS_RETURN, TIFS_AFTER, TIFS_SLEEP
  } tifs_state_t;

endpackage : tifs_pkg

/* File: timer_irq_flags_sleep_ctrl_bench.sv */
// Self-checking bench for the timer irq flag, dispatch and sleep block.
`timescale 1ns/1ps
module timer_irq_flags_sleep_ctrl_bench;
  import tifs_pkg::*;
  logic        ref_clk = 1'b0, rst = 1'b1;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  ev, stack_byte;
  logic [2:0]  lz, pwm;
  logic        t0_async, sleep_insn, reti_insn, ext_wake, slow, insn_boundary;
  logic        core_hold, pc_load, stack_push, stack_pop, osc_stop, sleeping;
  logic [15:0] core_pc, pc_value, stack_ptr, pushed, push_pc;
  int          n_errors = 0, n_tests = 0;
  always #25 ref_clk = ~ref_clk;
  tifs_ctrl i_dut (.ref_clk, .rst, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .t0_overflow(ev[0]), .t0_leave_zero(lz[0]), .t0_pwm_mode(pwm[0]), .t0_compare_hit(ev[1]),
    .t0_async, .t1_overflow(ev[2]), .t1_leave_zero(lz[1]), .t1_pwm_mode(pwm[1]),
    .t1_compare_a_hit(ev[4]), .t1_compare_b_hit(ev[3]), .t1_capture_done(ev[5]),
    .t2_overflow(ev[6]), .t2_leave_zero(lz[2]), .t2_pwm_mode(pwm[2]), .t2_compare_hit(ev[7]),
    .insn_boundary, .sleep_insn, .reti_insn, .core_pc, .ext_wake, .core_hold, .pc_load,
    .pc_value, .stack_push, .stack_pop, .stack_byte, .stack_ptr, .osc_stop, .sleeping);
  tifs_core_model i_core (.ref_clk, .rst, .slow, .core_hold, .pc_load, .pc_value,
    .stack_push, .stack_byte, .insn_boundary, .core_pc, .pushed, .push_pc);
  // ==========================================================================
  // Tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tmo(input int k);
    if (k >= 60) begin
      n_errors++;
      $display("unexpected wait timeout");
      finish_test();
    end
  endtask : tmo
  task automatic wait_lvl(ref logic s, input logic v);
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (s !== v && k < 60);
    tmo(k);
  endtask : wait_lvl
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
    int k;
    @(posedge ref_clk);
    awaddr <= {22'h0, a};
    wdata <= {24'h0, d};
    {awvalid, wvalid, bready} <= 3'h7;
    k = 0;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      k++;
    end while (!bvalid && k < 60);
    bready <= 1'b0;
    tmo(k);
    check("bresp", 32'(bresp), 32'(er));
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic [1:0] er);
    int k;
    @(posedge ref_clk);
    araddr <= {22'h0, a};
    {arvalid, rready} <= 2'h3;
    k = 0;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      k++;
    end while (!rvalid && k < 60);
    rready <= 1'b0;
    tmo(k);
    check("rdata", rdata, {24'h0, e});
    check("rresp", 32'(rresp), 32'(er));
  endtask : rd
  task automatic pulse(input logic [7:0] e, input logic [2:0] z);
    ev <= e;
    lz <= z;
    @(posedge ref_clk);
    ev <= 8'h00;
    lz <= 3'h0;
    @(posedge ref_clk);
  endtask : pulse
  task automatic serve(input logic [15:0] vec);
    wait_lvl(pc_load, 1'b1);
    check("vector", 32'(pc_value), 32'(vec));
    check("pushed pc", 32'(pushed), 32'(push_pc));
    wait_lvl(core_hold, 1'b0);
    reti_insn <= 1'b1;
    @(posedge ref_clk);
    reti_insn <= 1'b0;
    repeat (TIFS_RETURN_CYC + 1) @(posedge ref_clk);
    check("stack ptr", 32'(stack_ptr), 32'h0);
  endtask : serve
  task automatic sleep_now(input logic [7:0] ctl);
    wr(TIFS_CORE_CTL_ADDR, ctl, TIFS_RESP_OKAY);
    sleep_insn <= 1'b1;
    @(posedge ref_clk);
    sleep_insn <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : sleep_now
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  // ==========================================================================
  // Sequence
  initial begin
    int i;
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h0;
    {awaddr, wdata, araddr} <= 96'h0;
    wstrb <= 4'hF;
    {ev, lz, pwm} <= 14'h0;
    {t0_async, sleep_insn, reti_insn, ext_wake, slow} <= 5'h0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd(TIFS_FLAGS_ADDR, TIFS_FLAGS_RST, TIFS_RESP_OKAY);
    rd(10'h3FC, 8'h00, TIFS_RESP_SLVERR);
    wr(10'h3FC, 8'hFF, TIFS_RESP_SLVERR);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      pulse(8'h01 << i, 3'h0);
      rd(TIFS_FLAGS_ADDR, 8'h01 << i, TIFS_RESP_OKAY);
      wr(TIFS_FLAGS_ADDR, ~(8'h01 << i), TIFS_RESP_OKAY);
      rd(TIFS_FLAGS_ADDR, 8'h01 << i, TIFS_RESP_OKAY);
      wr(TIFS_FLAGS_ADDR, 8'h01 << i, TIFS_RESP_OKAY);
      rd(TIFS_FLAGS_ADDR, 8'h00, TIFS_RESP_OKAY);
    end
    pwm <= 3'h7;
    pulse(8'h45, 3'h0);
    rd(TIFS_FLAGS_ADDR, 8'h00, TIFS_RESP_OKAY);
    pulse(8'h00, 3'h7);
    rd(TIFS_FLAGS_ADDR, 8'h45, TIFS_RESP_OKAY);
    wr(TIFS_FLAGS_ADDR, 8'hFF, TIFS_RESP_OKAY);
    pwm <= 3'h0;
    $display("test flags done");
    wr(TIFS_ENABLES_ADDR, 8'hFF, TIFS_RESP_OKAY);
    pulse(8'h01, 3'h0);
    repeat (10) @(posedge ref_clk);
    check("idle hold", 32'(core_hold), 32'h0);
    wr(TIFS_CORE_CTL_ADDR, 8'h01, TIFS_RESP_OKAY);
    serve(TIFS_VEC_T0_OVF);
    for (i = 0; i < 8; i++) begin
      slow <= i[0];
      pulse(8'h01 << i, 3'h0);
      serve(16'h0020 - 16'(2 * i));
      rd(TIFS_FLAGS_ADDR, 8'h00, TIFS_RESP_OKAY);
    end
    slow <= 1'b0;
    pulse(8'h81, 3'h0);
    serve(16'h0020);
    serve(16'h0012);
    $display("test dispatch done");
    sleep_now(8'h01);
    check("sleep not allowed", 32'(sleeping), 32'h0);
    sleep_now(8'h03);
    check("idle sleep", 32'({sleeping, osc_stop}), 32'h2);
    pulse(8'h02, 3'h0);
    wait_lvl(sleeping, 1'b0);
    serve(16'h001E);
    sleep_now(8'h0B);
    pulse(8'h01, 3'h0);
    repeat (5) @(posedge ref_clk);
    check("power down", 32'({sleeping, osc_stop}), 32'h3);
    ext_wake <= 1'b1;
    wait_lvl(sleeping, 1'b0);
    ext_wake <= 1'b0;
    serve(TIFS_VEC_T0_OVF);
    t0_async <= 1'b1;
    sleep_now(8'h0F);
    pulse(8'h01, 3'h0);
    wait_lvl(sleeping, 1'b0);
    serve(TIFS_VEC_T0_OVF);
    sleep_now(8'h0F);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    check("reset wake", 32'({sleeping, core_hold}), 32'h0);
    rd(TIFS_CORE_CTL_ADDR, {4'h0, TIFS_CORE_CTL_RST}, TIFS_RESP_OKAY);
    $display("test sleep done");
    finish_test();
  end
endmodule : timer_irq_flags_sleep_ctrl_bench
